// ===== core/cts_consts.svh
// Contract
// - Converts continuously from reset; no start command exists or is needed.
// - Output result register refreshes once per conversion in normal mode, once per six in background mode; readable any time.
// - Input sampling runs at master clock divided by 256, independent of gain.
// - Every rate and calibration time derives from the one master clock.
// - Falling edge on sync_n resets filter and sequencing to a known state.
// - Devices sharing clock and one sync line update their outputs together.
// - Any calibration command resets the digital filter.
// - Mode code 001 starts self calibration: shorted node, then reference node.
// - result_ready_n goes high within one modulator cycle, low when calibration ends.
`ifndef CTS_CONSTS_SVH
`define CTS_CONSTS_SVH

`define CTS_DIV_W 8
`define CTS_PHASE_LAST 8'hff
`define CTS_PHASE_ZERO 8'h00
`define CTS_BG_LAST 3'h5
`define CTS_BG_REF 3'h1
`define CTS_STEP_ZERO 2'h0
`define CTS_STEP_REF 2'h1
`define CTS_STEPS_SELF 2'h2
`define CTS_STEPS_SYS 2'h1
`define CTS_DECIM_DEF 12

`endif

// ===== core/cts_conv_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "cts_consts.svh"
module cts_conv_ctrl #(
  parameter int DECIM_W = 12,
  parameter logic [DECIM_W-1:0] DECIM_DEF = DECIM_W'(`CTS_DECIM_DEF)
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sync_n,
  input wire logic mod_bit,
  input wire logic cmd_valid,
  input wire logic op_mode_select_2,
  input wire logic op_mode_select_1,
  input wire logic op_mode_select_0,
  input wire logic [DECIM_W-1:0] decim,
  input wire logic result_ack,
  output logic [DECIM_W:0] result_data,
  output logic result_ready_n,
  output logic cal_busy,
  output cts_pkg::cts_state_t seq_state
);
  import cts_pkg::*;

  cts_tick_if tif ();

  logic sync_prev_reg;
  logic [DECIM_W-1:0] samp_cnt_reg;
  logic [DECIM_W:0] acc_reg;
  logic [DECIM_W:0] offset_reg;
  logic [DECIM_W:0] fullscale_reg;
  logic [DECIM_W:0] result_reg;
  logic result_ready_n_reg;
  logic cal_busy_reg;
  cts_state_t state_reg;
  cts_state_t state_next;
  cts_mode_t mode_reg;
  logic [1:0] cal_step_reg;
  logic [2:0] bg_cnt_reg;

  function automatic logic is_cal(input cts_mode_t m);
    is_cal = (m == CTS_MODE_SELF) || (m == CTS_MODE_SYS_ZERO) || (m == CTS_MODE_SYS_FULL) ||
      (m == CTS_MODE_SYS_OFFS) || (m == CTS_MODE_BACKGND);
  endfunction

  function automatic logic [1:0] cal_last(input cts_mode_t m);
    cal_last = ((m == CTS_MODE_SELF) || (m == CTS_MODE_SYS_OFFS)) ? `CTS_STEPS_SELF : `CTS_STEPS_SYS;
  endfunction

  wire cts_mode_t cmd_mode = cts_mode_t'({op_mode_select_2, op_mode_select_1, op_mode_select_0});
  wire logic cal_cmd = cmd_valid && is_cal(cmd_mode);
  // Any command that is not a foreground calibration ends the busy phase.
  wire logic busy_cmd = cal_cmd && (cmd_mode != CTS_MODE_BACKGND);
  wire logic sync_fall = sync_prev_reg && !sync_n;
  wire logic [DECIM_W-1:0] decim_eff = (decim == '0) ? DECIM_DEF : decim;
  wire logic conv_done = tif.tick && (samp_cnt_reg == decim_eff - DECIM_W'(1));
  wire logic [DECIM_W:0] conv_val = acc_reg + (DECIM_W+1)'(mod_bit);
  wire logic cal_done = (state_reg == CTS_ST_CAL) && conv_done && (cal_step_reg == cal_last(mode_reg));
  wire logic bg_out = (state_reg == CTS_ST_BG) && conv_done && (bg_cnt_reg == `CTS_BG_LAST);
  // Plain conversions need no request; the sequencer free-runs from reset.
  wire logic run_out = (state_reg == CTS_ST_RUN) && conv_done;
  wire logic update = run_out || cal_done || bg_out;
  wire logic zero_cap = conv_done && (((state_reg == CTS_ST_CAL) && (cal_step_reg == `CTS_STEP_ZERO)
    && (mode_reg != CTS_MODE_SYS_FULL)) || ((state_reg == CTS_ST_BG) && (bg_cnt_reg == '0)));
  wire logic full_cap = conv_done && (((state_reg == CTS_ST_CAL) && (((cal_step_reg == `CTS_STEP_REF)
    && (mode_reg != CTS_MODE_SYS_ZERO)) || ((cal_step_reg == `CTS_STEP_ZERO)
    && (mode_reg == CTS_MODE_SYS_FULL)))) || ((state_reg == CTS_ST_BG) && (bg_cnt_reg == `CTS_BG_REF)));

  assign tif.restart = sync_fall || cal_cmd;
  assign result_data = result_reg;
  assign result_ready_n = result_ready_n_reg;
  assign cal_busy = cal_busy_reg;
  assign seq_state = state_reg;

  always_comb begin
    state_next = state_reg;
    if (cmd_valid) begin
      if (cmd_mode == CTS_MODE_BACKGND) begin
        state_next = CTS_ST_BG;
      end else if (is_cal(cmd_mode)) begin
        state_next = CTS_ST_CAL;
      end else begin
        state_next = CTS_ST_RUN;
      end
    end else if (cal_done) begin
      state_next = CTS_ST_RUN;
    end
  end

  cts_sample_timer u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .t(tif)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_prev_reg <= 1'b1;
      state_reg <= CTS_ST_RUN;
      mode_reg <= CTS_MODE_NORMAL;
    end else begin
      sync_prev_reg <= sync_n;
      state_reg <= state_next;
      mode_reg <= cmd_valid ? cmd_mode : mode_reg;
    end
  end

  // Filter: integrate-and-dump over decim samples, cleared by sync or calibration.
  always_ff @(posedge clk) begin
    if (sys_rst || tif.restart) begin
      samp_cnt_reg <= '0;
      acc_reg <= '0;
    end else if (conv_done) begin
      samp_cnt_reg <= '0;
      acc_reg <= '0;
    end else if (tif.tick) begin
      samp_cnt_reg <= samp_cnt_reg + DECIM_W'(1);
      acc_reg <= conv_val;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || tif.restart) begin
      cal_step_reg <= `CTS_STEP_ZERO;
      bg_cnt_reg <= '0;
    end else if (conv_done) begin
      cal_step_reg <= cal_step_reg + 2'h1;
      bg_cnt_reg <= (bg_cnt_reg == `CTS_BG_LAST) ? 3'h0 : bg_cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      offset_reg <= '0;
      fullscale_reg <= '0;
    end else begin
      offset_reg <= zero_cap ? conv_val : offset_reg;
      fullscale_reg <= full_cap ? conv_val : fullscale_reg;
    end
  end

  // The word only changes on an update, so an unsynchronised read sees a whole value.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      result_reg <= '0;
    end else if (update) begin
      result_reg <= conv_val - offset_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      result_ready_n_reg <= 1'b1;
      cal_busy_reg <= 1'b0;
    end else begin
      result_ready_n_reg <= cal_cmd ? 1'b1 : update ? 1'b0 : result_ack ? 1'b1 : result_ready_n_reg;
      cal_busy_reg <= cmd_valid ? busy_cmd : cal_done ? 1'b0 : cal_busy_reg;
    end
  end

  a_sync_reset: assert property (@(posedge clk) disable iff (sys_rst)
    sync_fall |=> (acc_reg == '0) && (samp_cnt_reg == '0) && (tif.phase == '0))
    else $error("sync edge did not clear filter");
  a_cal_reset: assert property (@(posedge clk) disable iff (sys_rst)
    cal_cmd |=> (acc_reg == '0) && (samp_cnt_reg == '0) && (state_reg != CTS_ST_RUN))
    else $error("calibration command did not reset filter");
  a_ready_rises: assert property (@(posedge clk) disable iff (sys_rst)
    cal_cmd |=> result_ready_n && cal_busy == (mode_reg != CTS_MODE_BACKGND))
    else $error("ready not released on calibration command");
  a_cal_ends: assert property (@(posedge clk) disable iff (sys_rst)
    (cal_done && !cmd_valid) |=> !result_ready_n && !cal_busy && state_reg == CTS_ST_RUN)
    else $error("calibration end not signalled");
  a_hold_word: assert property (@(posedge clk) disable iff (sys_rst)
    !update |=> $stable(result_data))
    else $error("result changed without update");
  a_update_on_tick: assert property (@(posedge clk) disable iff (sys_rst)
    update |-> tif.tick && tif.phase == `CTS_PHASE_LAST)
    else $error("update off the sample tick");
  a_free_running: assert property (@(posedge clk) disable iff (sys_rst)
    (run_out && !cmd_valid) |=> !result_ready_n)
    else $error("plain conversion did not publish");
  a_bg_ratio: assert property (@(posedge clk) disable iff (sys_rst)
    (update && state_reg == CTS_ST_BG) |-> bg_cnt_reg == `CTS_BG_LAST)
    else $error("background rate not one in six");
  c_sync_edge: cover property (@(posedge clk) disable iff (sys_rst) sync_fall);
  c_self_cal: cover property (@(posedge clk) disable iff (sys_rst)
    cal_done && mode_reg == CTS_MODE_SELF);
  c_bg_update: cover property (@(posedge clk) disable iff (sys_rst) bg_out);
endmodule // cts_conv_ctrl
`default_nettype wire

// ===== core/cts_pkg.sv
`default_nettype none
package cts_pkg;
  typedef enum logic [2:0] {
    CTS_MODE_NORMAL = 3'b000,
    CTS_MODE_SELF = 3'b001,
    CTS_MODE_SYS_ZERO = 3'b010,
    CTS_MODE_SYS_FULL = 3'b011,
    CTS_MODE_SYS_OFFS = 3'b100,
    CTS_MODE_BACKGND = 3'b101,
    CTS_MODE_RSVD6 = 3'b110,
    CTS_MODE_RSVD7 = 3'b111
  } cts_mode_t;

  typedef enum logic [1:0] {
    CTS_ST_RUN = 2'b00,
    CTS_ST_CAL = 2'b01,
    CTS_ST_BG = 2'b10
  } cts_state_t;
endpackage
`default_nettype wire

// ===== core/cts_sample_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "cts_consts.svh"
module cts_sample_timer (
  input wire logic clk,
  input wire logic sys_rst,
  cts_tick_if.gen t
);
  logic [`CTS_DIV_W-1:0] phase_reg;
  logic [`CTS_DIV_W-1:0] phase_next;
  logic [8:0] gap_reg;

  // Sample tick is the master clock divided by 256, so halving clk halves every rate.
  assign phase_next = t.restart ? `CTS_PHASE_ZERO : phase_reg + 8'h01;
  assign t.phase = phase_reg;
  assign t.tick = (phase_reg == `CTS_PHASE_LAST) && !t.restart;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_reg <= `CTS_PHASE_ZERO;
    end else begin
      phase_reg <= phase_next;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || t.restart || t.tick) begin
      gap_reg <= 9'h000;
    end else begin
      gap_reg <= gap_reg + 9'h001;
    end
  end

  a_tick_phase: assert property (@(posedge clk) disable iff (sys_rst)
    t.tick |-> t.phase == `CTS_PHASE_LAST)
    else $error("sample tick off phase");
  a_tick_gap: assert property (@(posedge clk) disable iff (sys_rst)
    gap_reg <= 9'h0ff)
    else $error("sample period exceeds 256 clocks");
  c_tick_seen: cover property (@(posedge clk) disable iff (sys_rst) t.tick);
endmodule // cts_sample_timer
`default_nettype wire

// ===== core/cts_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "cts_consts.svh"
interface cts_tick_if;
  logic restart;
  logic tick;
  logic [`CTS_DIV_W-1:0] phase;
  modport gen (input restart, output tick, output phase);
  modport use_side (output restart, input tick, input phase);
endinterface // cts_tick_if
`default_nettype wire

// ===== test/cts_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cts_host_model #(
  parameter int BOOT_WAIT = 300
) (
  input wire logic clk,
  input wire logic sys_rst,
  output logic sync_n
);
  int cnt;
  // One shared line pulses once, after every converter has left reset.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt <= 0;
      sync_n <= 1'b1;
    end else if (cnt < BOOT_WAIT + 4) begin
      cnt <= cnt + 1;
      sync_n <= !(cnt >= BOOT_WAIT);
    end else begin
      sync_n <= 1'b1;
    end
  end
endmodule // cts_host_model
`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cts_pkg::*;
  localparam int CONV = 2 * 256;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic rst_peer = 1'b1;
  logic mod_bit = 1'b1;
  logic cmd_valid = 1'b0;
  logic [2:0] mode = 3'h0;
  logic [11:0] decim = 12'h002;
  logic result_ack = 1'b0;
  logic sync_n;
  logic [12:0] result_data;
  logic [12:0] peer_data;
  logic result_ready_n;
  logic peer_ready_n;
  logic cal_busy;
  cts_state_t seq_state;
  int n_errors = 0;
  int comparisons = 0;
  int n;
  always #12.5 clk = ~clk;
  cts_host_model u_cts_host_model (.clk(clk), .sys_rst(sys_rst), .sync_n(sync_n));
  cts_conv_ctrl u_cts_conv_ctrl (.clk(clk), .sys_rst(sys_rst), .sync_n(sync_n),
    .mod_bit(mod_bit), .cmd_valid(cmd_valid), .op_mode_select_2(mode[2]),
    .op_mode_select_1(mode[1]), .op_mode_select_0(mode[0]), .decim(decim),
    .result_ack(result_ack), .result_data(result_data), .result_ready_n(result_ready_n),
    .cal_busy(cal_busy), .seq_state(seq_state));
  // The peer leaves reset later, so only the common sync can line it up.
  cts_conv_ctrl u_cts_conv_ctrl_peer (.clk(clk), .sys_rst(rst_peer), .sync_n(sync_n),
    .mod_bit(mod_bit), .cmd_valid(cmd_valid), .op_mode_select_2(mode[2]),
    .op_mode_select_1(mode[1]), .op_mode_select_0(mode[0]), .decim(decim),
    .result_ack(result_ack), .result_data(peer_data), .result_ready_n(peer_ready_n),
    .cal_busy(), .seq_state());
  task automatic check_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic check_word(input string what, input logic [12:0] exp, input logic [12:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_count(input string what, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      n_errors++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_ready(input int start, input logic [12:0] held);
    n = start;
    while (result_ready_n !== 1'b0 && n < 4000) begin
      @(posedge clk);
      #1;
      n++;
      if (result_ready_n !== 1'b0) check_word("held result", held, result_data);
    end
  endtask
  task automatic cmd(input logic [2:0] m);
    @(posedge clk);
    cmd_valid <= 1'b1;
    mode <= m;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
  endtask
  task automatic t_power_on();
    while (sync_n !== 1'b0) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    check_bit("peer ready early", 1'b1, peer_ready_n);
    wait_ready(0, 13'h0000);
    check_count("first update", CONV, n);
    check_word("first result", 13'h0002, result_data);
    check_bit("peer ready", 1'b0, peer_ready_n);
    check_word("peer result", 13'h0002, peer_data);
    $display("test power_on done");
  endtask
  task automatic t_hold();
    @(posedge clk);
    mod_bit <= 1'b0;
    @(posedge clk);
    result_ack <= 1'b1;
    @(posedge clk);
    result_ack <= 1'b0;
    #1;
    check_bit("ready after read", 1'b1, result_ready_n);
    wait_ready(3, 13'h0002);
    check_count("update period", CONV, n);
    check_word("second result", 13'h0000, result_data);
    $display("test hold done");
  endtask
  task automatic t_cal();
    for (int c = 1; c <= 5; c++) begin
      cmd(3'(c));
      check_bit("ready on cal", 1'b1, result_ready_n);
      check_bit("busy on cal", c != 5, cal_busy);
      check_word("cal state", (c == 5) ? 13'h0002 : 13'h0001, 13'(seq_state));
    end
    for (int c = 1; c <= 4; c++) begin
      cmd(3'(c));
      wait_ready(0, 13'h0000);
      check_count("cal length", ((c == 1 || c == 4) ? 3 : 2) * CONV, n);
      check_bit("busy after cal", 1'b0, cal_busy);
      check_word("state after cal", 13'h0000, 13'(seq_state));
    end
    cmd(3'h0);
    check_bit("ready on normal", 1'b0, result_ready_n);
    check_word("state on normal", 13'h0000, 13'(seq_state));
    cmd(3'h1);
    cmd(3'h7);
    check_bit("busy on reserved", 1'b0, cal_busy);
    check_bit("ready kept", 1'b1, result_ready_n);
    check_word("state on reserved", 13'h0000, 13'(seq_state));
    $display("test cal done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (100) @(posedge clk);
    rst_peer <= 1'b0;
    t_power_on();
    t_hold();
    t_cal();
    test_done();
  end
  initial begin
    #300000;
    n_errors++;
    test_done();
  end
endmodule // tb_top
`default_nettype wire
